// *** logic/hps_mux.sv ***
// Host port select mux: maps four shared pins to UART plus I2C or to SPI.
// Assumes peripheral cores on clk_sys; pins arrive asynchronously.
//
// How it works
// RL1: Strap high gives UART and I2C on pins; low gives SPI.
// RL2: SPI never runs together with UART or I2C; SPI disables both.
// RL3: Enabled indicator is active whenever its port is on and outgoing bytes reach the threshold, or one byte when the threshold is 0.
// RL4: Each port has its own indicator pin, never shared.
// RL5: Indicator polarity and byte threshold configurable; off after reset. The pin resets low, the active level when active_high is low.
// RL6: Host may wait on the indicator instead of polling I2C or SPI.
// RL7: UART rate configurable, 9600 baud after reset.
// RL8: UART is asynchronous only, with no handshake lines.
// RL9: In power save, a receive pin change raises a wake event in UART mode only.
// RL10: All pins pulled up; open strap selects UART and I2C.
// RL11: Strap sampled once leaving reset, mapping held until next reset.
`timescale 1ns/1ps
`default_nettype none

module hps_mux (
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        clk_en,
    input  wire logic        srst,
    // Strap and shared pins
    input  wire logic        strap_sel,
    input  wire logic [3:0]  pin_in,
    output logic      [3:0]  pin_out,
    output logic      [3:0]  pin_oe_n,
    output logic      [4:0]  pull_en,
    // Port enables
    output logic             uart_on,
    output logic             i2c_on,
    output logic             spi_on,
    // UART core side
    input  wire logic        uart_txd,
    output logic             uart_rxd,
    input  wire logic        baud_load,
    input  wire logic [15:0] baud_div_cfg,
    output logic      [15:0] baud_div,
    // I2C core side, open drain
    input  wire logic        i2c_scl_pull_low,
    input  wire logic        i2c_sda_pull_low,
    output logic             i2c_scl,
    output logic             i2c_sda,
    // SPI core side
    input  wire logic        spi_miso,
    output logic             spi_mosi,
    output logic             spi_sclk,
    output logic             spi_cs_n,
    // Power save wake
    input  wire logic        power_save,
    output logic             wake_pulse,
    // Transmit-pending configuration and state, per port
    input  wire logic [2:0]  txr_enable,
    input  wire logic [2:0]  txr_active_high,
    input  wire logic [7:0]  uart_txr_threshold,
    input  wire logic [7:0]  i2c_txr_threshold,
    input  wire logic [7:0]  spi_txr_threshold,
    input  wire logic [7:0]  uart_tx_bytes,
    input  wire logic [7:0]  i2c_tx_bytes,
    input  wire logic [7:0]  spi_tx_bytes,
    // Transmit-pending indicator pins
    output logic             uart_txr_pin,
    output logic             i2c_txr_pin,
    output logic             spi_txr_pin
);

    typedef struct packed {
        hps_pkg::hps_state_t fsm;
        logic                strap_meta;
        logic                strap_sync;
        logic [3:0]          pin_meta;
        logic [3:0]          pin_sync;
        logic                uart_sel;
        logic                uart_on;
        logic                i2c_on;
        logic                spi_on;
        logic [3:0]          pin_out;
        logic [3:0]          pin_oe_n;
        logic [4:0]          pull_en;
        logic                uart_rxd;
        logic                i2c_scl;
        logic                i2c_sda;
        logic                spi_mosi;
        logic                spi_sclk;
        logic                spi_cs_n;
        logic [15:0]         baud_div;
        logic                rxd_last;
        logic                wake;
    } hps_mux_state_t;

    hps_mux_state_t st_reg;
    hps_mux_state_t st_next;

    ////////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        st_next = st_reg;
        // Two-stage synchronisers for strap and pins
        st_next.strap_meta = strap_sel;
        st_next.strap_sync = st_reg.strap_meta;
        st_next.pin_meta   = pin_in;
        st_next.pin_sync   = st_reg.pin_meta;
        st_next.wake       = 1'b0;

        // RL11 sample strap once
        unique case (st_reg.fsm)
            hps_pkg::HPS_ST_FILL1: st_next.fsm = hps_pkg::HPS_ST_FILL2;
            hps_pkg::HPS_ST_FILL2: st_next.fsm = hps_pkg::HPS_ST_FILL3;
            // Synchroniser now holds the strap level, not its reset value
            hps_pkg::HPS_ST_FILL3: begin
                st_next.fsm      = hps_pkg::HPS_ST_RUN;
                st_next.uart_sel = st_reg.strap_sync;
            end
            hps_pkg::HPS_ST_RUN: st_next.fsm = hps_pkg::HPS_ST_RUN;
        endcase

        // RL2 exclusive port enables
        st_next.uart_on = (st_next.fsm == hps_pkg::HPS_ST_RUN) && st_next.uart_sel;
        st_next.i2c_on  = (st_next.fsm == hps_pkg::HPS_ST_RUN) && st_next.uart_sel;
        st_next.spi_on  = (st_next.fsm == hps_pkg::HPS_ST_RUN) && !st_next.uart_sel;

        // RL10 pull-ups always on
        st_next.pull_en = hps_pkg::PULL_EN_RST;

        // RL1 pin mapping
        // RL8 only data lines, no handshake
        st_next.pin_out  = hps_pkg::PIN_OUT_RST;
        st_next.pin_oe_n = hps_pkg::PIN_OE_N_RST;
        if (st_reg.uart_on) begin
            st_next.pin_out[hps_pkg::PIN_TXD_MISO]  = uart_txd;
            st_next.pin_oe_n[hps_pkg::PIN_TXD_MISO] = 1'b0;
            st_next.pin_oe_n[hps_pkg::PIN_SCL_SCLK] = !i2c_scl_pull_low;
            st_next.pin_oe_n[hps_pkg::PIN_SDA_CS]   = !i2c_sda_pull_low;
        end else if (st_reg.spi_on) begin
            // MISO driven only while selected
            st_next.pin_out[hps_pkg::PIN_TXD_MISO]  = spi_miso;
            st_next.pin_oe_n[hps_pkg::PIN_TXD_MISO] = st_reg.pin_sync[hps_pkg::PIN_SDA_CS];
        end

        // Core inputs, idle levels for inactive ports
        st_next.uart_rxd = st_reg.uart_on ? st_reg.pin_sync[hps_pkg::PIN_RXD_MOSI] : 1'b1;
        st_next.i2c_scl  = st_reg.i2c_on ? st_reg.pin_sync[hps_pkg::PIN_SCL_SCLK] : 1'b1;
        st_next.i2c_sda  = st_reg.i2c_on ? st_reg.pin_sync[hps_pkg::PIN_SDA_CS] : 1'b1;
        st_next.spi_mosi = st_reg.spi_on && st_reg.pin_sync[hps_pkg::PIN_RXD_MOSI];
        st_next.spi_sclk = st_reg.spi_on && st_reg.pin_sync[hps_pkg::PIN_SCL_SCLK];
        st_next.spi_cs_n = st_reg.spi_on ? st_reg.pin_sync[hps_pkg::PIN_SDA_CS] : 1'b1;

        // RL7 baud divisor load
        if (baud_load) begin
            st_next.baud_div = baud_div_cfg;
        end

        // RL9 wake on receive change
        st_next.rxd_last = st_reg.pin_sync[hps_pkg::PIN_RXD_MOSI];
        st_next.wake     = power_save && st_reg.uart_on
                           && (st_reg.rxd_last != st_reg.pin_sync[hps_pkg::PIN_RXD_MOSI]);
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register, frozen while clk_en and srst are both low
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            st_reg            <= '0;
            st_reg.fsm        <= hps_pkg::HPS_ST_FILL1;
            st_reg.strap_meta <= 1'b1;
            st_reg.strap_sync <= 1'b1;
            st_reg.uart_sel   <= 1'b1;
            st_reg.pin_meta   <= hps_pkg::PIN_IN_RST;
            st_reg.pin_sync   <= hps_pkg::PIN_IN_RST;
            st_reg.rxd_last   <= 1'b1;
            st_reg.pin_out    <= hps_pkg::PIN_OUT_RST;
            st_reg.pin_oe_n   <= hps_pkg::PIN_OE_N_RST;
            st_reg.pull_en    <= hps_pkg::PULL_EN_RST;
            st_reg.uart_rxd   <= 1'b1;
            st_reg.i2c_scl    <= 1'b1;
            st_reg.i2c_sda    <= 1'b1;
            st_reg.spi_cs_n   <= 1'b1;
            st_reg.baud_div   <= hps_pkg::BAUD_DIV_RST;
        end else if (clk_en) begin
            st_reg <= st_next;
        end
    end

    // Outputs straight from the state register
    assign pin_out    = st_reg.pin_out;
    assign pin_oe_n   = st_reg.pin_oe_n;
    assign pull_en    = st_reg.pull_en;
    assign uart_on    = st_reg.uart_on;
    assign i2c_on     = st_reg.i2c_on;
    assign spi_on     = st_reg.spi_on;
    assign uart_rxd   = st_reg.uart_rxd;
    assign i2c_scl    = st_reg.i2c_scl;
    assign i2c_sda    = st_reg.i2c_sda;
    assign spi_mosi   = st_reg.spi_mosi;
    assign spi_sclk   = st_reg.spi_sclk;
    assign spi_cs_n   = st_reg.spi_cs_n;
    assign baud_div   = st_reg.baud_div;
    assign wake_pulse = st_reg.wake;

    ////////////////////////////////////////////////////////////////////////////
    // RL4 one indicator per port
    hps_txr_ind u_txr_uart (
        .clk_sys       (clk_sys),
        .clk_en        (clk_en),
        .srst          (srst),
        .ind_enable    (txr_enable[0]),
        .active_high   (txr_active_high[0]),
        .threshold     (uart_txr_threshold),
        .port_on       (st_reg.uart_on),
        .pending_bytes (uart_tx_bytes),
        .ind_pin       (uart_txr_pin)
    );

    hps_txr_ind u_txr_i2c (
        .clk_sys       (clk_sys),
        .clk_en        (clk_en),
        .srst          (srst),
        .ind_enable    (txr_enable[1]),
        .active_high   (txr_active_high[1]),
        .threshold     (i2c_txr_threshold),
        .port_on       (st_reg.i2c_on),
        .pending_bytes (i2c_tx_bytes),
        .ind_pin       (i2c_txr_pin)
    );

    hps_txr_ind u_txr_spi (
        .clk_sys       (clk_sys),
        .clk_en        (clk_en),
        .srst          (srst),
        .ind_enable    (txr_enable[2]),
        .active_high   (txr_active_high[2]),
        .threshold     (spi_txr_threshold),
        .port_on       (st_reg.spi_on),
        .pending_bytes (spi_tx_bytes),
        .ind_pin       (spi_txr_pin)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    a_spi_excludes_others: assert property (@(posedge clk_sys) disable iff (srst) // RL2
        !(spi_on && (uart_on || i2c_on)))
        else $error("SPI active together with UART or I2C");

    a_uart_maps_txd: assert property (@(posedge clk_sys) disable iff (srst) // RL1
        clk_en && uart_on |=> !pin_oe_n[0] && pin_out[0] == $past(uart_txd))
        else $error("UART transmit not on shared pin");

    a_spi_inputs_only: assert property (@(posedge clk_sys) disable iff (srst) // RL1
        spi_on |-> pin_oe_n[3:1] == 3'h7)
        else $error("SPI input pins driven");

    a_map_held_fixed: assert property (@(posedge clk_sys) disable iff (srst) // RL11
        (uart_on || spi_on) |=> $stable(uart_on) && $stable(spi_on))
        else $error("pin mapping changed after start-up");

    a_map_after_start: assert property (@(posedge clk_sys) disable iff (srst) // RL11
        $fell(srst) && clk_en ##1 clk_en [*2]
        |-> !(uart_on || spi_on) ##1 (uart_on || spi_on))
        else $error("no port selected after start-up");

    a_baud_reset_value: assert property (@(posedge clk_sys) // RL7
        $past(srst) |-> baud_div == hps_pkg::BAUD_DIV_RST)
        else $error("baud divisor wrong after reset");

    a_wake_on_change: assert property (@(posedge clk_sys) disable iff (srst) // RL9
        clk_en && power_save && uart_on && st_reg.rxd_last != st_reg.pin_sync[1]
        |=> wake_pulse)
        else $error("receive change in power save gave no wake");

    a_pullups_on: assert property (@(posedge clk_sys) disable iff (srst) // RL10
        pull_en == hps_pkg::PULL_EN_RST)
        else $error("pull-up disabled");

endmodule

`default_nettype wire

// *** logic/hps_pkg.sv ***
// Shared constants for the host port select mux.
// Assumes a single 20 MHz system clock and a synchronous active-high reset.
package hps_pkg;

    // Clock and UART rate
    localparam int unsigned CLK_HZ        = 20_000_000;
    localparam int unsigned BAUD_DEFAULT  = 9600;
    localparam logic [15:0] BAUD_DIV_RST  = 16'(CLK_HZ / BAUD_DEFAULT);

    // Shared pin positions
    localparam int unsigned PIN_TXD_MISO  = 0;
    localparam int unsigned PIN_RXD_MOSI  = 1;
    localparam int unsigned PIN_SCL_SCLK  = 2;
    localparam int unsigned PIN_SDA_CS    = 3;
    localparam int unsigned PIN_COUNT     = 4;
    localparam int unsigned PULL_COUNT    = 5;

    // Values after reset
    localparam logic [3:0]  PIN_OE_N_RST  = 4'hf;
    localparam logic [3:0]  PIN_OUT_RST   = 4'h0;
    localparam logic [3:0]  PIN_IN_RST    = 4'hf;
    localparam logic [4:0]  PULL_EN_RST   = 5'h1f;
    localparam logic [7:0]  BYTE_ONE      = 8'h01;

    // Start-up sequence: two cycles fill the strap synchroniser, one samples it
    typedef enum logic [1:0] {
        HPS_ST_FILL1 = 2'b00,
        HPS_ST_FILL2 = 2'b01,
        HPS_ST_FILL3 = 2'b11,
        HPS_ST_RUN   = 2'b10
    } hps_state_t;

endpackage

// *** logic/hps_txr_ind.sv ***
// Transmit-pending indicator for one host port.
// Assumes byte count and configuration come from logic on clk_sys.
`timescale 1ns/1ps
`default_nettype none

module hps_txr_ind (
    // Clock and reset
    input  wire logic       clk_sys,
    input  wire logic       clk_en,
    input  wire logic       srst,
    // Configuration
    input  wire logic       ind_enable,
    input  wire logic       active_high,
    input  wire logic [7:0] threshold,
    // Port state
    input  wire logic       port_on,
    input  wire logic [7:0] pending_bytes,
    // Indicator pin
    output logic            ind_pin
);

    typedef struct packed {
        logic ind;
    } hps_txr_state_t;

    hps_txr_state_t st_reg;
    hps_txr_state_t st_next;
    logic           active;
    logic [7:0]     level;

    ////////////////////////////////////////////////////////////////////////////
    // RL3 assert when pending
    // RL5 threshold and polarity
    always_comb begin
        level   = (threshold == 8'h00) ? hps_pkg::BYTE_ONE : threshold;
        active  = ind_enable && port_on && (pending_bytes >= level);
        st_next = st_reg;
        st_next.ind = active ? active_high : ~active_high;
    end

    // State register
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            st_reg <= '0;
        end else if (clk_en) begin
            st_reg <= st_next;
        end
    end

    assign ind_pin = st_reg.ind;

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    a_ind_pending_level: assert property (@(posedge clk_sys) disable iff (srst) // RL3
        clk_en && ind_enable && port_on && pending_bytes >= level
        |=> ind_pin == $past(active_high))
        else $error("indicator not active with bytes pending");

    a_ind_idle_level: assert property (@(posedge clk_sys) disable iff (srst) // RL5
        clk_en && (!ind_enable || pending_bytes < level)
        |=> ind_pin != $past(active_high))
        else $error("indicator active while disabled or below threshold");

endmodule

`default_nettype wire

// *** test/hps_host.sv ***
// Host-side pin model for the host port select mux.
// Assumes the bench sets host_val and host_en shortly after a clock edge.
`timescale 1ns/1ps
`default_nettype none

module hps_host (
    // Design side of the shared pins
    input  wire logic [3:0] pin_out,
    input  wire logic [3:0] pin_oe_n,
    // Host drive requests from the bench
    input  wire logic [3:0] host_val,
    input  wire logic [3:0] host_en,
    // Resolved pin levels
    output logic      [3:0] pin_in
);

    ////////////////////////////////////////////////////////////////////////////
    // pull-up resolution
    // A released pin floats to the pull-up; a low from either party wins.
    // Only the four data pins exist: the host has no handshake lines.
    always_comb begin
        for (int b = 0; b < 4; b++) begin
            pin_in[b] = (pin_oe_n[b] ? 1'b1 : pin_out[b]) & (host_en[b] ? host_val[b] : 1'b1);
        end
    end

endmodule
`default_nettype wire

// *** test/test_host_port_select_mux.sv ***
// Self-checking bench for the host port select mux.
// Assumes the host model in hps_host.sv and a 20 MHz clk_sys.
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin fails++; \
    $display("[ERR] %s exp %h got %h", nm, e, g); end end

module test_host_port_select_mux;

    logic        clk_sys, clk_en, srst, strap_sel, uart_txd, uart_rxd, baud_load;
    logic [3:0]  pin_out, pin_oe_n, host_val, host_en;
    logic [4:0]  pull_en;
    logic        uart_on, i2c_on, spi_on, scl_low, sda_low, i2c_scl, i2c_sda;
    logic        spi_miso, spi_mosi, spi_sclk, spi_cs_n, power_save, wake_pulse;
    logic [15:0] baud_div_cfg, baud_div;
    logic [2:0]  txr_enable, txr_active_high;
    logic [7:0]  thr [3];
    logic [7:0]  nbytes [3];
    wire  [3:0]  pin_in;
    wire  [2:0]  txr_pins;
    wire         spi_txr_pin = txr_pins[2];
    int          fails, n_tests, wakes, w0;

    hps_mux dut (.clk_sys(clk_sys), .clk_en(clk_en), .srst(srst), .strap_sel(strap_sel),
        .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .pull_en(pull_en),
        .uart_on(uart_on), .i2c_on(i2c_on), .spi_on(spi_on), .uart_txd(uart_txd),
        .uart_rxd(uart_rxd), .baud_load(baud_load), .baud_div_cfg(baud_div_cfg),
        .baud_div(baud_div), .i2c_scl_pull_low(scl_low), .i2c_sda_pull_low(sda_low),
        .i2c_scl(i2c_scl), .i2c_sda(i2c_sda), .spi_miso(spi_miso), .spi_mosi(spi_mosi),
        .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .power_save(power_save),
        .wake_pulse(wake_pulse), .txr_enable(txr_enable), .txr_active_high(txr_active_high),
        .uart_txr_threshold(thr[0]), .i2c_txr_threshold(thr[1]), .spi_txr_threshold(thr[2]),
        .uart_tx_bytes(nbytes[0]), .i2c_tx_bytes(nbytes[1]), .spi_tx_bytes(nbytes[2]),
        .uart_txr_pin(txr_pins[0]), .i2c_txr_pin(txr_pins[1]), .spi_txr_pin(txr_pins[2]));

    hps_host host (.pin_out(pin_out), .pin_oe_n(pin_oe_n), .host_val(host_val),
        .host_en(host_en), .pin_in(pin_in));

    ////////////////////////////////////////////////////////////////////////////
    // Clock generation, 50 ns period
    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end

    // Count wake pulses seen on the output
    always @(posedge clk_sys) begin
        if (wake_pulse === 1'b1) wakes++;
    end

    // Watchdog against a hung run
    initial begin
        #(50 * 20000);
        fails++;
        complete_run;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Verdict and end of run
    task automatic complete_run;
        if (fails == 0 && n_tests > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    // Advance n edges, then settle just after the last one
    task automatic step(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask

    // Reset with the strap at the given level
    task automatic do_reset(input logic s);
        srst = 1'b1;
        strap_sel = s;
        step(5);
        srst = 1'b0;
        step(4);
    endtask

    // Indicator level expected from configuration and byte count
    function automatic logic exp_ind(logic en, logic ah, logic on, logic [7:0] t,
                                     logic [7:0] b);
        logic [7:0] tt;
        tt = (t == 8'h00) ? 8'h01 : t;
        return (en && on && b >= tt) ? ah : !ah;
    endfunction

    // Random indicator configurations, boundary counts favoured
    task automatic chk_ind(input int n, input logic [2:0] on);
        for (int i = 0; i < n; i++) begin
            txr_enable = (i == 0) ? 3'h7 : 3'($urandom);
            txr_active_high = 3'($urandom);
            for (int p = 0; p < 3; p++) begin
                thr[p] = (i == 0) ? 8'hff : 8'($urandom_range(0, 4));
                nbytes[p] = (i == 0) ? 8'hff : 8'($urandom_range(0, 4));
            end
            step(2);
            for (int p = 0; p < 3; p++) begin
                `CHK("txr_pin", exp_ind(txr_enable[p], txr_active_high[p], on[p], thr[p],
                     nbytes[p]), txr_pins[p])
            end
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        void'($urandom(38));
        {srst, strap_sel, uart_txd, baud_load, scl_low, sda_low} = '0;
        {spi_miso, power_save, fails, n_tests, wakes} = '0;
        clk_en = 1'b1;
        baud_div_cfg = 16'h0000;
        host_val = 4'hf;
        host_en = 4'h2;
        txr_enable = 3'h0;
        txr_active_high = 3'h5;
        thr = '{8'h01, 8'h01, 8'h01};
        nbytes = '{8'h05, 8'h05, 8'h05};
        do_reset(1'b1);
        `CHK("ports_uart", 3'b110, {uart_on, i2c_on, spi_on})
        `CHK("pull_en", 5'h1f, pull_en)
        `CHK("baud_rst", hps_pkg::BAUD_DIV_RST, baud_div)
        `CHK("txr_rst", 3'h2, txr_pins)
        strap_sel = 1'b0;
        step(6);
        `CHK("strap_hold", 3'b110, {uart_on, i2c_on, spi_on})
        for (int i = 0; i < 8; i++) begin
            uart_txd = 1'($urandom);
            host_val[1] = 1'($urandom);
            step(4);
            `CHK("txd_pin", uart_txd, pin_out[0])
            `CHK("txd_oe_n", 2'b10, pin_oe_n[1:0])
            `CHK("rxd_core", host_val[1], uart_rxd)
        end
        for (int i = 0; i < 4; i++) begin
            {sda_low, scl_low} = 2'(i);
            step(4);
            `CHK("i2c_oe_n", ~{sda_low, scl_low}, pin_oe_n[3:2])
            `CHK("i2c_lines", ~{sda_low, scl_low}, {i2c_sda, i2c_scl})
        end
        {host_en[3], host_val[3], sda_low, scl_low} = 4'b1000;
        step(4);
        `CHK("sda_host", 1'b0, i2c_sda)
        host_en[3] = 1'b0;
        baud_load = 1'b1;
        baud_div_cfg = 16'($urandom);
        step(1);
        `CHK("baud_a", baud_div_cfg, baud_div)
        baud_div_cfg = 16'hffff;
        step(1);
        baud_load = 1'b0;
        `CHK("baud_b", 16'hffff, baud_div)
        power_save = 1'b1;
        for (int i = 0; i < 3; i++) begin
            if (i == 2) power_save = 1'b0;
            w0 = wakes;
            host_val[1] = ~host_val[1];
            step(8);
            `CHK("wake_cnt", (i < 2) ? 1 : 0, wakes - w0)
        end
        chk_ind(20, 3'b011);
        host_en = 4'he;
        host_val = 4'h7;
        do_reset(1'b0);
        `CHK("ports_spi", 3'b001, {uart_on, i2c_on, spi_on})
        for (int i = 0; i < 6; i++) begin
            host_val[2:1] = 2'($urandom);
            spi_miso = 1'($urandom);
            step(4);
            `CHK("spi_in", {host_val[2:1], 1'b0}, {spi_sclk, spi_mosi, spi_cs_n})
            `CHK("miso_pin", {1'b0, spi_miso}, {pin_oe_n[0], pin_out[0]})
            `CHK("idle_others", 3'b111, {uart_rxd, i2c_scl, i2c_sda})
        end
        // Clock enable low freezes the pin state
        clk_en = 1'b0;
        spi_miso = ~spi_miso;
        step(3);
        `CHK("freeze", ~spi_miso, pin_out[0])
        clk_en = 1'b1;
        step(1);
        `CHK("thaw", spi_miso, pin_out[0])
        host_val[3] = 1'b1;
        step(4);
        `CHK("miso_off", 1'b1, pin_oe_n[0])
        power_save = 1'b1;
        w0 = wakes;
        host_val[1] = ~host_val[1];
        step(8);
        `CHK("wake_spi", 0, wakes - w0)
        chk_ind(20, 3'b100);
        // Host waits on the indicator while bytes accumulate, bounded
        txr_enable = 3'h4;
        txr_active_high = 3'h4;
        thr[2] = 8'h03;
        nbytes[2] = 8'h00;
        step(2);
        w0 = 0;
        while (spi_txr_pin !== 1'b1 && w0 < 8) begin
            w0++;
            nbytes[2] = 8'(w0);
            step(2);
        end
        `CHK("txr_wait", 8'h03, nbytes[2])
        if (w0 == 8) complete_run;
        strap_sel = 1'b1;
        step(6);
        `CHK("strap_hold2", 3'b001, {uart_on, i2c_on, spi_on})
        complete_run;
    end

endmodule
`default_nettype wire
